/* hdl/iams_pkg.sv */
// package: register map, field layout, states and pin carrier of the ack sequencer
// Notes on behaviour
// - setting the ack sequence enable bit (bit 4 of control two) starts an acknowledge sequence.
// - at the start the block pulls SCL low and puts the ack data value on SDA.
// - after driving the ack level the block waits one baud period, then releases SCL.
// - the block waits until SCL is sampled high, counts another baud period, then pulls SCL low.
// - at the end hardware clears the enable bit, stops the baud generator and goes idle.
// - a buffer write during a sequence sets the write collision flag and leaves the buffer alone.
package iams_pkg;

    // ****************************************
    // register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [9:0] IDX_BUFFER   = 10'h013;
    localparam logic [9:0] IDX_CONTROL  = 10'h014;
    localparam logic [9:0] IDX_STATUS   = 10'h094;
    localparam logic [9:0] IDX_CONTROL2 = 10'h015;
    localparam logic [9:0] IDX_BAUD     = 10'h016;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h017;
    localparam logic [9:0] IDX_IRQ_CLR  = 10'h018;
    localparam logic [9:0] IDX_IRQ_EN   = 10'h019;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int BIT_WRITE_COLLISION_FLAG       = 7;
    localparam int BIT_ACK_ENABLE = 4;
    localparam int BIT_ACK_DATA   = 5;
    localparam int IRQ_DONE       = 0;
    localparam int IRQ_WRITE_COLLISION_FLAG       = 1;
    localparam int IRQ_W          = 2;

    localparam logic [7:0] RST_CONTROL  = 8'h00;
    localparam logic [7:0] RST_CONTROL2 = 8'h00;
    localparam logic [7:0] RST_STATUS   = 8'h00;
    localparam logic [7:0] RST_BUFFER   = 8'h00;
    localparam logic [7:0] STATUS_WMASK = 8'hC0;
    // baud period is reload + 1 clock cycles
    localparam logic [7:0] RST_BAUD     = 8'h09;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'b0_0001,
        ST_LOW  = 5'b0_0010,
        ST_REL  = 5'b0_0100,
        ST_HIGH = 5'b0_1000,
        ST_FIN  = 5'b1_0000
    } iams_state_t;

    typedef struct packed {
        logic sclOut;
        logic sclOe;
        logic sdaOut;
        logic sdaOe;
    } iams_pins_t;

    function automatic logic regHit(input logic [11:0] addr, input logic [9:0] idx);
        return addr == {idx, 2'b00};
    endfunction : regHit

endpackage : iams_pkg

/* hdl/iams_baud.sv */
// baud rate generator: reloads while stopped, one-cycle tick on every rollover
`timescale 1ns/10ps
module iams_baud
    import iams_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [7:0] reload,
    output logic            tick
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;

    always_comb begin
        if (!run || cnt_reg == 8'h00) begin
            cnt_next = reload;
        end else begin
            cnt_next = cnt_reg - 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_reg <= RST_BAUD;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign tick = run && cnt_reg == 8'h00;
endmodule : iams_baud

/* hdl/iams_irq.sv */
// sticky event status, enable mask, write-one-to-clear, one level interrupt
`timescale 1ns/10ps
module iams_irq
    import iams_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [IRQ_W-1:0]  evt,
    input  wire logic              clrWr,
    input  wire logic              enWr,
    input  wire logic [IRQ_W-1:0]  wrData,
    output logic      [IRQ_W-1:0]  status,
    output logic      [IRQ_W-1:0]  enable,
    output logic                   irq
);
    logic [IRQ_W-1:0] stat_reg;
    logic [IRQ_W-1:0] stat_next;
    logic [IRQ_W-1:0] en_reg;
    logic [IRQ_W-1:0] en_next;

    // set wins over a clear in the same cycle
    always_comb begin
        stat_next = (stat_reg & ~(clrWr ? wrData : '0)) | evt;
        en_next   = enWr ? wrData : en_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stat_reg <= '0;
            en_reg   <= '0;
        end else begin
            stat_reg <= stat_next;
            en_reg   <= en_next;
        end
    end

    assign status = stat_reg;
    assign enable = en_reg;
    assign irq    = |(stat_reg & en_reg);
endmodule : iams_irq

/* hdl/iams_ack_seq.sv */
// two-wire master acknowledge sequencer with APB register slave
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
module iams_ack_seq
    import iams_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sclIn,
    output iams_pins_t       pins,
    output logic             irq
);
    // ****************************************
    // bus decode
    // ****************************************
    logic wrEn;
    logic rdSetup;
    logic hitBuf;
    logic hitCtl;
    logic hitSta;
    logic hitCtl2;
    logic hitBaud;
    logic hitIStat;
    logic hitIClr;
    logic hitIEn;
    logic mapped;

    always_comb begin
        hitBuf   = regHit(paddr, IDX_BUFFER);
        hitCtl   = regHit(paddr, IDX_CONTROL);
        hitSta   = regHit(paddr, IDX_STATUS);
        hitCtl2  = regHit(paddr, IDX_CONTROL2);
        hitBaud  = regHit(paddr, IDX_BAUD);
        hitIStat = regHit(paddr, IDX_IRQ_STAT);
        hitIClr  = regHit(paddr, IDX_IRQ_CLR);
        hitIEn   = regHit(paddr, IDX_IRQ_EN);
        mapped   = hitBuf | hitCtl | hitSta | hitCtl2 | hitBaud | hitIStat | hitIClr | hitIEn;
        wrEn     = psel && penable && pwrite && mapped;
        rdSetup  = psel && !penable && !pwrite;
    end

    // no wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ****************************************
    // registers and sequencer state
    // ****************************************
    iams_state_t      state_reg;
    iams_state_t      state_next;
    logic [7:0]       buf_reg;
    logic [7:0]       buf_next;
    logic [7:0]       ctl_reg;
    logic [7:0]       ctl_next;
    logic [7:0]       sta_reg;
    logic [7:0]       sta_next;
    logic [7:0]       ctl2_reg;
    logic [7:0]       ctl2_next;
    logic [7:0]       baud_reg;
    logic [7:0]       baud_next;
    logic             ackDat_reg;
    logic             ackDat_next;
    logic [31:0]      rd_reg;
    logic [31:0]      rd_next;
    iams_pins_t       pins_reg;
    iams_pins_t       pins_next;
    logic             busy;
    logic             baudRun;
    logic             baudTick;
    logic             wcolEvt;
    logic             doneEvt;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] irqEnable;

    assign busy = state_reg != ST_IDLE;

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        state_next  = state_reg;
        ackDat_next = ackDat_reg;
        case (state_reg)
            ST_IDLE: begin
                if (ctl2_reg[BIT_ACK_ENABLE]) begin
                    state_next  = ST_LOW;
                    ackDat_next = ctl2_reg[BIT_ACK_DATA];
                end
            end
            ST_LOW: begin
                if (baudTick) begin
                    state_next = ST_REL;
                end
            end
            ST_REL: begin
                if (sclIn) begin
                    state_next = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (baudTick) begin
                    state_next = ST_FIN;
                end
            end
            ST_FIN: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    assign baudRun = state_reg == ST_LOW || state_reg == ST_HIGH;
    assign doneEvt = state_reg == ST_FIN;
    assign wcolEvt = wrEn && hitBuf && busy;

    // open-drain pins: only ever pull low, enable high while pulling
    always_comb begin
        pins_next.sclOut = 1'b0;
        pins_next.sdaOut = 1'b0;
        // SCL low, ack level on SDA
        pins_next.sclOe  = state_next == ST_LOW || state_next == ST_FIN;
        pins_next.sdaOe  = state_next != ST_IDLE && !ackDat_next;
    end

    // ****************************************
    // register writes
    // ****************************************
    always_comb begin
        buf_next  = buf_reg;
        ctl_next  = ctl_reg;
        sta_next  = sta_reg;
        ctl2_next = ctl2_reg;
        baud_next = baud_reg;
        if (wrEn && hitBuf && !busy) begin
            buf_next = pwdata[7:0];
        end
        if (wrEn && hitCtl) begin
            ctl_next = pwdata[7:0];
        end
        // collision flag, set wins over clear
        if (wcolEvt) begin
            ctl_next[BIT_WRITE_COLLISION_FLAG] = 1'b1;
        end
        if (wrEn && hitSta) begin
            sta_next = pwdata[7:0] & STATUS_WMASK;
        end
        // hardware owns the enable bit while a sequence runs
        if (wrEn && hitCtl2) begin
            ctl2_next = pwdata[7:0];
            if (busy) begin
                ctl2_next[BIT_ACK_ENABLE] = ctl2_reg[BIT_ACK_ENABLE];
            end
        end
        if (doneEvt) begin
            ctl2_next[BIT_ACK_ENABLE] = 1'b0;
        end
        if (wrEn && hitBaud) begin
            baud_next = pwdata[7:0];
        end
    end

    // read data is captured in the setup cycle, so it reflects that cycle's state
    always_comb begin
        rd_next = 32'h0000_0000;
        if (rdSetup) begin
            if (hitBuf) begin
                rd_next[7:0] = buf_reg;
            end else if (hitCtl) begin
                rd_next[7:0] = ctl_reg;
            end else if (hitSta) begin
                rd_next[7:0] = sta_reg;
            end else if (hitCtl2) begin
                rd_next[7:0] = ctl2_reg;
            end else if (hitBaud) begin
                rd_next[7:0] = baud_reg;
            end else if (hitIStat) begin
                rd_next[IRQ_W-1:0] = irqStatus;
            end else if (hitIEn) begin
                rd_next[IRQ_W-1:0] = irqEnable;
            end
        end else begin
            rd_next = rd_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg  <= ST_IDLE;
            buf_reg    <= RST_BUFFER;
            ctl_reg    <= RST_CONTROL;
            sta_reg    <= RST_STATUS;
            ctl2_reg   <= RST_CONTROL2;
            baud_reg   <= RST_BAUD;
            ackDat_reg <= 1'b0;
            rd_reg     <= 32'h0000_0000;
            pins_reg   <= '0;
        end else begin
            state_reg  <= state_next;
            buf_reg    <= buf_next;
            ctl_reg    <= ctl_next;
            sta_reg    <= sta_next;
            ctl2_reg   <= ctl2_next;
            baud_reg   <= baud_next;
            ackDat_reg <= ackDat_next;
            rd_reg     <= rd_next;
            pins_reg   <= pins_next;
        end
    end

    assign prdata = rd_reg;
    assign pins   = pins_reg;

    // ****************************************
    // baud generator and interrupt
    // ****************************************
    iams_baud u_baud (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .run     (baudRun),
        .reload  (baud_reg),
        .tick    (baudTick)
    );

    iams_irq u_irq (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .evt     ({wcolEvt, doneEvt}),
        .clrWr   (wrEn && hitIClr),
        .enWr    (wrEn && hitIEn),
        .wrData  (pwdata[IRQ_W-1:0]),
        .status  (irqStatus),
        .enable  (irqEnable),
        .irq     (irq)
    );

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_start;
        state_reg == ST_IDLE && ctl2_reg[BIT_ACK_ENABLE] |=> state_reg == ST_LOW;
    endproperty
    a_start: assert property (p_start) else $error("enable did not start sequence");

    property p_drive;
        state_reg == ST_LOW |-> pins.sclOe && pins.sdaOe == !ackDat_reg;
    endproperty
    a_drive: assert property (p_drive) else $error("ack level not driven");

    property p_release;
        state_reg == ST_LOW && baudTick |=> state_reg == ST_REL && !pins.sclOe;
    endproperty
    a_release: assert property (p_release) else $error("scl not released");

    property p_hold;
        state_reg == ST_LOW && !baudTick |=> state_reg == ST_LOW && pins.sclOe;
    endproperty
    a_hold: assert property (p_hold) else $error("scl released early");

    property p_stretch;
        state_reg == ST_REL && !sclIn |=> state_reg == ST_REL && !pins.sclOe;
    endproperty
    a_stretch: assert property (p_stretch) else $error("stretch ignored");

    property p_low_again;
        state_reg == ST_HIGH && baudTick |=> pins.sclOe ##1 state_reg == ST_IDLE;
    endproperty
    a_low_again: assert property (p_low_again) else $error("scl not pulled low");

    property p_finish;
        state_reg == ST_FIN |=> !ctl2_reg[BIT_ACK_ENABLE] && !baudRun && !pins.sdaOe;
    endproperty
    a_finish: assert property (p_finish) else $error("sequence not ended");

    property p_write_collision_flag;
        wrEn && hitBuf && busy |=> ctl_reg[BIT_WRITE_COLLISION_FLAG] && $stable(buf_reg);
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

    property p_irq;
        state_reg == ST_FIN |=> irqStatus[IRQ_DONE] && state_reg == ST_IDLE;
    endproperty
    a_irq: assert property (p_irq) else $error("done flag missing");

    c_full: cover property (state_reg == ST_HIGH ##1 state_reg == ST_FIN);
    c_stretch: cover property ((state_reg == ST_REL && !sclIn) [*3]);
    c_write_collision_flag: cover property (wcolEvt);
    c_nack: cover property (state_reg == ST_LOW && ackDat_reg);
endmodule : iams_ack_seq

/* verif/iams_slave_model.sv */
// two-wire slave model: stretches SCL after release and captures the ack bit
`timescale 1ns/10ps
module iams_slave_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       sclOe,
    input  wire logic       sdaOe,
    input  wire logic [1:0] stretch,
    output logic            sclHold,
    output logic            ackSeen
);
    logic [1:0] holdCnt_reg;
    logic       sclPrev_reg;
    logic       sclWire;

    // open drain: low if anyone pulls, pulled up otherwise
    assign sclWire = !(sclOe | sclHold);
    assign sclHold = holdCnt_reg != 2'h0;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            holdCnt_reg <= 2'h0;
            sclPrev_reg <= 1'b1;
            ackSeen     <= 1'b1;
        end else begin
            // only stretch once the master lets go of the clock
            if (sclOe) begin
                holdCnt_reg <= stretch;
            end else if (sclHold) begin
                holdCnt_reg <= holdCnt_reg - 2'h1;
            end
            sclPrev_reg <= sclWire;
            // taken at the falling edge: idle release would spoil a rising-edge capture
            if (!sclWire && sclPrev_reg) begin
                ackSeen <= !sdaOe;
            end
        end
    end
endmodule : iams_slave_model

/* verif/testbench.sv */
// self-checking bench for the acknowledge sequencer
`timescale 1ns/10ps
module testbench
    import iams_pkg::*;
;
    localparam logic [7:0] RELOAD = 8'h02;
    localparam int         N      = 3;
    localparam logic [9:0] R_IDX [9] = '{IDX_BUFFER, IDX_CONTROL, IDX_STATUS, IDX_CONTROL2,
        IDX_BAUD, IDX_IRQ_STAT, IDX_IRQ_CLR, IDX_IRQ_EN, 10'h03F};
    localparam logic [7:0] R_VAL [9] = '{RST_BUFFER, RST_CONTROL, RST_STATUS, RST_CONTROL2,
        RST_BAUD, 8'h00, 8'h00, 8'h00, 8'h00};

    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [1:0]  stretch = 2'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq, sclIn, sclHold, ackSeen, sda, sdaBad;
    iams_pins_t  pins;
    logic [32:0] rdQ[$];
    logic [32:0] seqQ[$];
    logic [31:0] rng = 32'h0000_539e;
    int          nFail = 0;
    int          samplesChecked = 0;
    int          seqCnt = 0;
    int          ph = 0;
    int          lo, hi, st;

    always #5 ref_clk = ~ref_clk;
    assign sclIn = !(pins.sclOe | sclHold);

    iams_ack_seq i_iams_ack_seq (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclIn(sclIn), .pins(pins), .irq(irq));
    iams_slave_model i_iams_slave_model (.ref_clk(ref_clk), .rst_n(rst_n),
        .sclOe(pins.sclOe), .sdaOe(pins.sdaOe), .stretch(stretch), .sclHold(sclHold),
        .ackSeen(ackSeen));

    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rnd

    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic endSim();
        $display("compared %0d, mismatched %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : endSim

    // ****************************************
    // apb master: held until pready is seen high
    // ****************************************
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            nFail++;
            endSim();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic err);
        rdQ.push_back({err, exp});
        apb(1'b0, idx, rnd());
    endtask : rd

    // ****************************************
    // output watcher: read data and pin waveform
    // ****************************************
    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite) begin
            if (rdQ.size() == 0) nFail++;
            else cmp({pslverr, prdata}, rdQ.pop_front());
        end
        if (ph == 1 || ph == 2) sdaBad = sdaBad | (pins.sdaOe !== sda);
        case (ph)
            0: if (pins.sclOe === 1'b1) begin
                ph = 1;
                lo = 1;
                sda = pins.sdaOe;
                sdaBad = 1'b0;
            end
            1: if (pins.sclOe === 1'b1) lo++;
            else begin
                ph = 2;
                hi = int'(sclIn);
                st = int'(!sclIn);
            end
            2: if (pins.sclOe === 1'b1) ph = 3;
            else if (sclIn) hi++;
            else st++;
            default: begin
                ph = 0;
                if (seqQ.size() < 5) nFail++;
                else begin
                    cmp(33'(lo), seqQ.pop_front());
                    cmp({31'h0, sdaBad, sda}, seqQ.pop_front());
                    cmp(33'(hi), seqQ.pop_front());
                    cmp(33'(st), seqQ.pop_front());
                    // all four pin fields must be back to zero once the port is idle
                    cmp({31'h0, |pins, irq}, seqQ.pop_front());
                end
                seqCnt++;
            end
        endcase
    end

    initial begin : main
        logic [31:0] bufVal;
        logic        ack, coll;
        int          k, j, n, s;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        for (k = 0; k < 9; k++) rd(R_IDX[k], {24'h0, R_VAL[k]}, k == 8);
        apb(1'b1, IDX_STATUS, 32'h0000_00FF);
        rd(IDX_STATUS, {24'h0, STATUS_WMASK}, 1'b0);
        apb(1'b1, IDX_IRQ_STAT, 32'h0000_0003);
        rd(IDX_IRQ_STAT, 32'h0000_0000, 1'b0);
        apb(1'b1, IDX_BAUD, {24'h0, RELOAD});
        bufVal = rnd() & 32'h0000_00FF;
        apb(1'b1, IDX_BUFFER, bufVal);
        for (k = 0; k < 4; k++) begin
            ack  = k[0];
            coll = k[1];
            // k or k+1, modulo 4: at least two runs stretch, whatever the random bit is
            s = int'((32'(k) + (rnd() & 32'h0000_0001)) & 32'h0000_0003);
            stretch <= 2'(s);
            // interrupt unmasked only on collision runs, masked otherwise
            apb(1'b1, IDX_IRQ_EN, {31'h0, coll});
            apb(1'b1, IDX_CONTROL2, {26'h0, ack, 5'h00});
            seqQ.push_back(33'(N));
            seqQ.push_back({32'h0, !ack});
            seqQ.push_back(33'(N + 1));
            seqQ.push_back(33'(s));
            seqQ.push_back({32'h0, coll});
            n = seqCnt;
            apb(1'b1, IDX_CONTROL2, {26'h0, ack, 5'h10});
            if (coll) begin
                apb(1'b1, IDX_BUFFER, rnd());
                // enable is hardware-owned while busy: a clearing write must not stop the run
                apb(1'b1, IDX_CONTROL2, {26'h0, ack, 5'h00});
                rd(IDX_CONTROL2, {26'h0, ack, 5'h10}, 1'b0);
            end
            for (j = 0; j < 100 && seqCnt == n; j++) @(posedge ref_clk);
            if (seqCnt == n) begin
                nFail++;
                endSim();
            end
            cmp({32'h0, ackSeen}, {32'h0, ack});
            rd(IDX_CONTROL2, {26'h0, ack, 5'h00}, 1'b0);
            rd(IDX_BUFFER, bufVal, 1'b0);
            rd(IDX_CONTROL, {24'h0, coll, 7'h00}, 1'b0);
            rd(IDX_IRQ_STAT, {30'h0, coll, 1'b1}, 1'b0);
            apb(1'b1, IDX_IRQ_CLR, 32'h0000_0003);
            apb(1'b1, IDX_CONTROL, 32'h0000_0000);
            rd(IDX_IRQ_STAT, 32'h0000_0000, 1'b0);
            cmp({32'h0, irq}, 33'h0_0000_0000);
        end
        endSim();
    end

    // a hang is cut short at 500 us, far beyond the length of a normal run
    initial begin
        #500_000;
        nFail++;
        endSim();
    end
endmodule : testbench
